/* File: pkg/eeprom_cfg_pkg.sv */
// Summary of operation
// - Word 00h must be 1516h; 02h,04h,08h,0Ah give the identifier fields.
// - Word 06h bit 0 loads extended channel count, 144h bit 0, all ports.
// - Word 06h bits 3:1 and 6:4 load exit latencies, CCh 14:12, 17:15.
// - Port 0 74h bits 5,6 take word 06h bits 8,9, ordering relaxations.
// - Port 0 74h bits 4:0 take word 06h bits 14:10, switching mode.
// - Word 06h bit 15 loads 3Ch bit 8 on ports 1 and 2.
// - Word 0Ch bits 1:0 load max payload support, C4h bits 1:0.
// - Word 0Ch bits 3:2 load power-state link support, CCh bits 11:10.
// - Word 0Ch bit 4 loads role-based error reporting, C4h bit 15.
// - Word 0Ch bit 5 loads message interrupt disable, 70h bit 14.
// - Word 0Ch bit 6 loads compliance parity disable, 74h bit 15.
// - Word 0Ch bit 7 loads power management disable, 70h bit 13.
// - Word 0Ch bit 8 loads posted-pass-nonposted enable, 8Ch bit 5.
// - Word 0Ch bit 9 loads bandwidth notification, CCh bit 21, ports 1-2.
// - Word 0Ch bit 10 loads ordering freeze, 8Ch bit 6.
// - Word 0Ch bit 11 loads start-of-frame latency mode, 8Ch bit 0.
// - Word 0Ch bit 12 loads surprise-down reporting, CCh bit 19.
// - Word 0Ch bit 13 loads data select writability, 8Ch bit 1.
// - Word 0Ch bit 14 loads latency tolerance reporting, E4h bit 12.
// - Word 0Ch bit 15 loads 4KB boundary check enable, 8Ch bit 3.
// - Word 0Eh loads three 5-bit margin drive levels, 94h bits 14:0.
// - Word 0Eh bit 15 loads buffer flush and fill enable, E4h bit 18.
package eeprom_cfg_pkg;

  localparam int ADDR_W = 12;
  localparam int EE_ADDR_W = 8;

  // EEPROM byte addresses of the words
  localparam logic [7:0] EE_SIG = 8'h00;
  localparam logic [7:0] EE_VENDOR = 8'h02;
  localparam logic [7:0] EE_DEVICE = 8'h04;
  localparam logic [7:0] EE_MODE = 8'h06;
  localparam logic [7:0] EE_SSVID = 8'h08;
  localparam logic [7:0] EE_SSID = 8'h0a;
  localparam logic [7:0] EE_CAPS = 8'h0c;
  localparam logic [7:0] EE_MARGIN = 8'h0e;
  localparam logic [7:0] EE_STEP = 8'h02;
  localparam logic [15:0] SIGNATURE = 16'h1516;

  // Configuration offsets inside one port
  localparam logic [9:0] CFG_ID = 10'h000;
  localparam logic [9:0] CFG_INTPIN = 10'h03c;
  localparam logic [9:0] CFG_CAPDIS = 10'h070;
  localparam logic [9:0] CFG_SWMODE = 10'h074;
  localparam logic [9:0] CFG_TLCTL = 10'h08c;
  localparam logic [9:0] CFG_MARGIN = 10'h094;
  localparam logic [9:0] CFG_SUBSYS = 10'h0b4;
  localparam logic [9:0] CFG_DEVCAP = 10'h0c4;
  localparam logic [9:0] CFG_LINKCAP = 10'h0cc;
  localparam logic [9:0] CFG_DEVCAP2 = 10'h0e4;
  localparam logic [9:0] CFG_EXTVC = 10'h144;

  // Loader control and status, in the fourth port slot
  localparam logic [1:0] LDR_SLOT = 2'h3;
  localparam logic [9:0] LDR_CTRL = 10'h000;
  localparam logic [9:0] LDR_STATUS = 10'h004;
  localparam int CTRL_RELOAD = 0;
  localparam int ST_DONE_BIT = 0;
  localparam int ST_SIGOK_BIT = 1;
  localparam int ST_SIGBAD_BIT = 2;

  // Destination bit positions
  localparam int POS_INTA = 8;
  localparam int POS_MSI_DIS = 14;
  localparam int POS_PM_DIS = 13;
  localparam int POS_SAF = 0;
  localparam int POS_CT_THR = 1;
  localparam int POS_ARB = 3;
  localparam int POS_CREDIT = 4;
  localparam int POS_NO_ORD_EGR = 5;
  localparam int POS_NO_ORD_TAG = 6;
  localparam int POS_CPAR_DIS = 15;
  localparam int POS_SOF_LAT = 0;
  localparam int POS_PMDS_RW = 1;
  localparam int POS_BCHK4K = 3;
  localparam int POS_PP_NP = 5;
  localparam int POS_FROZEN = 6;
  localparam int POS_MPS = 0;
  localparam int POS_RBER = 15;
  localparam int POS_ASPM = 10;
  localparam int POS_L0S = 12;
  localparam int POS_L1 = 15;
  localparam int POS_SURPRISE = 19;
  localparam int POS_LBN = 21;
  localparam int POS_LTR = 12;
  localparam int POS_OBFF = 18;
  localparam int POS_EXTVC = 0;

  // Word 06h layout
  typedef struct packed {
    logic inta_req;
    logic credit_mode;
    logic arb_mode;
    logic [1:0] ct_thr;
    logic saf;
    logic no_ord_tag;
    logic no_ord_egr;
    logic spare;
    logic [2:0] l1_lat;
    logic [2:0] l0s_lat;
    logic ext_vc;
  } mode_word_t;

  // Word 0Ch layout
  typedef struct packed {
    logic bchk4k;
    logic ltr;
    logic pmds_rw;
    logic surprise_dn;
    logic sof_lat;
    logic frozen;
    logic lbn;
    logic posted_pass_nonposted_enable;
    logic pm_dis;
    logic cpar_dis;
    logic msi_dis;
    logic rber;
    logic [1:0] aspm;
    logic [1:0] mps;
  } caps_word_t;

  // Word 0Eh layout
  typedef struct packed {
    logic obff;
    logic [4:0] margin_drive_level_half_swing;
    logic [4:0] margin_drive_level_high_deemph;
    logic [4:0] margin_drive_level_low_deemph;
  } margin_word_t;

  typedef struct packed {
    logic [15:0] vendor;
    logic [15:0] device;
    mode_word_t mode;
    logic [15:0] ssvid;
    logic [15:0] ssid;
    caps_word_t caps;
    margin_word_t margin;
  } cfg_image_t;

  localparam cfg_image_t IMAGE_RST = '0;

endpackage

/* File: verilog/eeprom_config_word_loader.sv */
// Design decisions made here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module eeprom_config_word_loader (
  input wire logic clk_i,
  input wire logic rstn_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [eeprom_cfg_pkg::ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // EEPROM word reader
  output logic ee_req_o,
  output logic [eeprom_cfg_pkg::EE_ADDR_W-1:0] ee_addr_o,
  input wire logic ee_ack_i,
  input wire logic [15:0] ee_data_i,
  // Loaded configuration towards the switch
  output eeprom_cfg_pkg::cfg_image_t cfg_image_o,
  output logic load_done_o
);

  typedef enum logic [1:0] {ST_REQ, ST_WAIT, ST_IDLE} ldr_state_t;

  ldr_state_t state_r;
  logic [7:0] addr_r;
  logic ee_req_r;
  logic done_r;
  logic sig_ok_r;
  logic sig_bad_r;
  eeprom_cfg_pkg::cfg_image_t image_r;
  logic resp_r;
  logic err_r;
  logic [31:0] prdata_r;
  logic word_in;
  logic sig_fail;
  logic last_word;
  logic reload;
  logic [32:0] rd_nxt;

  assign word_in = (state_r == ST_WAIT) && ee_ack_i;
  assign sig_fail = word_in && (addr_r == eeprom_cfg_pkg::EE_SIG) &&
                    (ee_data_i != eeprom_cfg_pkg::SIGNATURE);
  assign last_word = addr_r == eeprom_cfg_pkg::EE_MARGIN;
  // Reload only from idle; a write is taken at the pready edge
  assign reload = resp_r && pwrite_i && done_r && pstrb_i[0] &&
                  (paddr_i[11:10] == eeprom_cfg_pkg::LDR_SLOT) &&
                  (paddr_i[9:0] == eeprom_cfg_pkg::LDR_CTRL) &&
                  pwdata_i[eeprom_cfg_pkg::CTRL_RELOAD];

  // Load sequencer: one word per request, signature first
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state_r <= ST_REQ;
      addr_r <= 8'h00;
      ee_req_r <= 1'b0;
    end
    else
    begin
      unique case (state_r)
        ST_REQ:
        begin
          ee_req_r <= 1'b1;
          state_r <= ST_WAIT;
        end
        ST_WAIT:
        begin
          if (ee_ack_i)
          begin
            ee_req_r <= 1'b0;
            if (sig_fail || last_word)
              state_r <= ST_IDLE;
            else
            begin
              addr_r <= 8'(addr_r + eeprom_cfg_pkg::EE_STEP);
              state_r <= ST_REQ;
            end
          end
        end
        ST_IDLE:
        begin
          if (reload)
          begin
            addr_r <= eeprom_cfg_pkg::EE_SIG;
            state_r <= ST_REQ;
          end
        end
      endcase
    end
  end

  // Load status
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      done_r <= 1'b0;
      sig_ok_r <= 1'b0;
      sig_bad_r <= 1'b0;
    end
    else if (reload)
    begin
      done_r <= 1'b0;
      sig_ok_r <= 1'b0;
      sig_bad_r <= 1'b0;
    end
    else if (word_in)
    begin
      if (sig_fail)
      begin
        done_r <= 1'b1;
        sig_bad_r <= 1'b1;
      end
      else if (addr_r == eeprom_cfg_pkg::EE_SIG)
        sig_ok_r <= 1'b1;
      if (last_word)
        done_r <= 1'b1;
    end
  end

  // Image capture; a reload first restores defaults
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      image_r <= eeprom_cfg_pkg::IMAGE_RST;
    else if (reload)
      image_r <= eeprom_cfg_pkg::IMAGE_RST;
    else if (word_in)
    begin
      unique case (addr_r)
        eeprom_cfg_pkg::EE_VENDOR: image_r.vendor <= ee_data_i;
        eeprom_cfg_pkg::EE_DEVICE: image_r.device <= ee_data_i;
        eeprom_cfg_pkg::EE_MODE: image_r.mode <= ee_data_i;
        eeprom_cfg_pkg::EE_SSVID: image_r.ssvid <= ee_data_i;
        eeprom_cfg_pkg::EE_SSID: image_r.ssid <= ee_data_i;
        eeprom_cfg_pkg::EE_CAPS: image_r.caps <= ee_data_i;
        eeprom_cfg_pkg::EE_MARGIN: image_r.margin <= ee_data_i;
        default: image_r <= image_r;
      endcase
    end
  end

  // Per-port view: one stored copy, fanned out to all ports
  function automatic logic [32:0] cfg_read(
    input logic [1:0] port,
    input logic [9:0] off,
    input eeprom_cfg_pkg::cfg_image_t im,
    input logic dn,
    input logic ok,
    input logic bad
  );
    logic [31:0] d;
    logic hit;
    logic up;
    d = 32'h0000_0000;
    hit = 1'b1;
    up = port != 2'h0;
    if (port == eeprom_cfg_pkg::LDR_SLOT)
    begin
      if (off == eeprom_cfg_pkg::LDR_STATUS)
      begin
        d[eeprom_cfg_pkg::ST_DONE_BIT] = dn;
        d[eeprom_cfg_pkg::ST_SIGOK_BIT] = ok;
        d[eeprom_cfg_pkg::ST_SIGBAD_BIT] = bad;
      end
      else if (off != eeprom_cfg_pkg::LDR_CTRL)
        hit = 1'b0;
    end
    else
    begin
      unique case (off)
        eeprom_cfg_pkg::CFG_ID: d = {im.device, im.vendor};
        eeprom_cfg_pkg::CFG_INTPIN:
          d[eeprom_cfg_pkg::POS_INTA] = up & im.mode.inta_req;
        eeprom_cfg_pkg::CFG_CAPDIS:
        begin
          d[eeprom_cfg_pkg::POS_MSI_DIS] = im.caps.msi_dis;
          d[eeprom_cfg_pkg::POS_PM_DIS] = im.caps.pm_dis;
        end
        eeprom_cfg_pkg::CFG_SWMODE:
        begin
          if (!up)
          begin
            d[eeprom_cfg_pkg::POS_NO_ORD_EGR] = im.mode.no_ord_egr;
            d[eeprom_cfg_pkg::POS_NO_ORD_TAG] = im.mode.no_ord_tag;
            d[eeprom_cfg_pkg::POS_SAF] = im.mode.saf;
            d[eeprom_cfg_pkg::POS_CT_THR +: 2] = im.mode.ct_thr;
            d[eeprom_cfg_pkg::POS_ARB] = im.mode.arb_mode;
            d[eeprom_cfg_pkg::POS_CREDIT] = im.mode.credit_mode;
          end
          d[eeprom_cfg_pkg::POS_CPAR_DIS] = im.caps.cpar_dis;
        end
        eeprom_cfg_pkg::CFG_TLCTL:
        begin
          d[eeprom_cfg_pkg::POS_PP_NP] =
            im.caps.posted_pass_nonposted_enable;
          d[eeprom_cfg_pkg::POS_FROZEN] = im.caps.frozen;
          d[eeprom_cfg_pkg::POS_SOF_LAT] = im.caps.sof_lat;
          d[eeprom_cfg_pkg::POS_PMDS_RW] = im.caps.pmds_rw;
          d[eeprom_cfg_pkg::POS_BCHK4K] = im.caps.bchk4k;
        end
        eeprom_cfg_pkg::CFG_MARGIN:
          d[14:0] = im.margin[14:0];
        eeprom_cfg_pkg::CFG_SUBSYS: d = {im.ssid, im.ssvid};
        eeprom_cfg_pkg::CFG_DEVCAP:
        begin
          d[eeprom_cfg_pkg::POS_MPS +: 2] = im.caps.mps;
          d[eeprom_cfg_pkg::POS_RBER] = im.caps.rber;
        end
        eeprom_cfg_pkg::CFG_LINKCAP:
        begin
          d[eeprom_cfg_pkg::POS_ASPM +: 2] = im.caps.aspm;
          d[eeprom_cfg_pkg::POS_L0S +: 3] = im.mode.l0s_lat;
          d[eeprom_cfg_pkg::POS_L1 +: 3] = im.mode.l1_lat;
          d[eeprom_cfg_pkg::POS_SURPRISE] = im.caps.surprise_dn;
          d[eeprom_cfg_pkg::POS_LBN] = up & im.caps.lbn;
        end
        eeprom_cfg_pkg::CFG_DEVCAP2:
        begin
          d[eeprom_cfg_pkg::POS_LTR] = im.caps.ltr;
          d[eeprom_cfg_pkg::POS_OBFF] = im.margin.obff;
        end
        eeprom_cfg_pkg::CFG_EXTVC:
          d[eeprom_cfg_pkg::POS_EXTVC] = im.mode.ext_vc;
        default: hit = 1'b0;
      endcase
    end
    return {hit, d};
  endfunction

  assign rd_nxt = cfg_read(paddr_i[11:10], paddr_i[9:0], image_r,
                           done_r, sig_ok_r, sig_bad_r);

  // APB answer: held off until the load is done, then one wait state
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      resp_r <= 1'b0;
      err_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end
    else if (resp_r)
      resp_r <= 1'b0;
    else if (psel_i && penable_i && done_r)
    begin
      resp_r <= 1'b1;
      err_r <= ~rd_nxt[32];
      // Loaded fields are read-only here; writes only touch control
      prdata_r <= (pwrite_i || !rd_nxt[32]) ? 32'h0000_0000 : rd_nxt[31:0];
    end
  end

  assign pready_o = resp_r;
  assign pslverr_o = resp_r & err_r;
  assign prdata_o = prdata_r;
  assign ee_req_o = ee_req_r;
  assign ee_addr_o = addr_r;
  assign cfg_image_o = image_r;
  assign load_done_o = done_r;

  AST_NO_ACCESS_EARLY: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    !done_r |-> !pready_o)
    else $error("Config access answered before load done");

  AST_SIG_SKIP: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    sig_fail |=> done_r && sig_bad_r && !ee_req_o &&
                 image_r == eeprom_cfg_pkg::IMAGE_RST ##1 !ee_req_o)
    else $error("Bad signature did not stop the load");

  AST_SIG_NEXT: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    word_in && addr_r == eeprom_cfg_pkg::EE_SIG && !sig_fail
    |=> ##1 ee_req_o && ee_addr_o == eeprom_cfg_pkg::EE_VENDOR)
    else $error("Good signature did not advance to vendor word");

  AST_VENDOR_LOAD: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    word_in && addr_r == eeprom_cfg_pkg::EE_VENDOR
    |=> image_r.vendor == $past(ee_data_i))
    else $error("Vendor word not stored");

  AST_MODE_LOAD: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    word_in && addr_r == eeprom_cfg_pkg::EE_MODE
    |=> image_r.mode == $past(ee_data_i))
    else $error("Mode word not stored");

  AST_CAPS_LOAD: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    word_in && addr_r == eeprom_cfg_pkg::EE_CAPS
    |=> image_r.caps == $past(ee_data_i))
    else $error("Capability word not stored");

  AST_MARGIN_LOAD: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    word_in && addr_r == eeprom_cfg_pkg::EE_MARGIN
    |=> image_r.margin == $past(ee_data_i))
    else $error("Margin word not stored");

  // Reader may be slow; request and address must wait for it
  AST_REQ_HOLD: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    ee_req_o && !ee_ack_i |=> ee_req_o && $stable(ee_addr_o))
    else $error("Word request dropped before its answer");

  AST_ADDR_STEP: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    word_in && !sig_fail && !last_word
    |=> ee_addr_o == 8'($past(ee_addr_o) + eeprom_cfg_pkg::EE_STEP))
    else $error("Word address did not step by one word");

  AST_LAST_DONE: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    word_in && last_word |=> done_r && !ee_req_o ##1 !ee_req_o)
    else $error("Load did not finish after the last word");

  AST_RELOAD_CLEAR: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    reload |=> !done_r && !sig_ok_r && !sig_bad_r &&
               image_r == eeprom_cfg_pkg::IMAGE_RST)
    else $error("Reload did not restore the defaults");

  AST_MODE_P0_READ: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    psel_i && penable_i && !pwrite_i && !resp_r && done_r &&
    paddr_i == {2'h0, eeprom_cfg_pkg::CFG_SWMODE}
    |=> pready_o && prdata_o[6:0] == {image_r.mode.no_ord_tag,
        image_r.mode.no_ord_egr, image_r.mode.credit_mode,
        image_r.mode.arb_mode, image_r.mode.ct_thr, image_r.mode.saf})
    else $error("Port 0 switch mode readback wrong");

  AST_INTA_PORT0_ZERO: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    psel_i && penable_i && !pwrite_i && !resp_r && done_r &&
    paddr_i == {2'h0, eeprom_cfg_pkg::CFG_INTPIN}
    |=> prdata_o == 32'h0000_0000)
    else $error("Port 0 interrupt pin bit must stay clear");

  AST_LBN_UPPER: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    psel_i && penable_i && !pwrite_i && !resp_r && done_r &&
    paddr_i == {2'h2, eeprom_cfg_pkg::CFG_LINKCAP}
    |=> prdata_o[eeprom_cfg_pkg::POS_LBN] == image_r.caps.lbn &&
        prdata_o[14:12] == image_r.mode.l0s_lat)
    else $error("Port 2 link capability readback wrong");

  AST_MARGIN_READ: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    psel_i && penable_i && !pwrite_i && !resp_r && done_r &&
    paddr_i == {2'h1, eeprom_cfg_pkg::CFG_MARGIN}
    |=> prdata_o == {17'h0, image_r.margin[14:0]})
    else $error("Margin readback wrong");

  AST_UNMAPPED_ERR: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    psel_i && penable_i && !resp_r && done_r &&
    paddr_i[11:10] == eeprom_cfg_pkg::LDR_SLOT &&
    paddr_i[9:0] == 10'h008
    |=> pready_o && pslverr_o)
    else $error("Unmapped access not flagged");

  AST_READY_PULSE: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    pready_o |=> !pready_o)
    else $error("Ready stood longer than one cycle");

  AST_WRITE_NO_DATA: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    psel_i && penable_i && pwrite_i && !resp_r && done_r
    |=> pready_o && prdata_o == 32'h0000_0000)
    else $error("Write answered with data");

  COV_BAD_SIG: cover property (@(posedge clk_i) disable iff (!rstn_i)
    sig_fail);
  COV_FULL_LOAD: cover property (@(posedge clk_i) disable iff (!rstn_i)
    word_in && last_word ##1 done_r && sig_ok_r);
  COV_RELOAD: cover property (@(posedge clk_i) disable iff (!rstn_i)
    reload ##[1:40] done_r);
  COV_ACCESS_STALL: cover property (@(posedge clk_i) disable iff (!rstn_i)
    psel_i && penable_i && !done_r);

endmodule

/* File: verif/eeprom_word_model.sv */
`timescale 1ns/1ps
module eeprom_word_model (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic req_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0][15:0] words_i,
  input wire logic [3:0] delay_i,
  output logic ack_o,
  output logic [15:0] data_o
);
  logic [3:0] wait_r;

  // Data turns over when idle, so a late sample sees garbage
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      wait_r <= 4'h0;
      ack_o <= 1'b0;
      data_o <= 16'h0;
    end
    else if (req_i && !ack_o && wait_r >= delay_i)
    begin
      ack_o <= 1'b1;
      data_o <= words_i[addr_i[3:1]];
      wait_r <= 4'h0;
    end
    else
    begin
      ack_o <= 1'b0;
      data_o <= ~data_o;
      wait_r <= (req_i && !ack_o) ? wait_r + 4'h1 : 4'h0;
    end
  end
endmodule

/* File: verif/eeprom_config_word_loader_tb.sv */
`timescale 1ns/1ps
module eeprom_config_word_loader_tb;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic ee_req;
  logic [7:0] ee_addr;
  logic ee_ack;
  logic [15:0] ee_data;
  eeprom_cfg_pkg::cfg_image_t cfg_image;
  logic load_done;
  logic [7:0][15:0] words;
  logic [7:0][15:0] pat [3];
  logic [3:0] delay = 4'h4;
  logic [9:0] offs [11] = '{10'h000, 10'h03c, 10'h070, 10'h074, 10'h08c,
    10'h094, 10'h0b4, 10'h0c4, 10'h0cc, 10'h0e4, 10'h144};
  int error_cnt = 0;
  int n_compared = 0;
  int ack_n = 0;
  int ack_base = 0;
  logic [31:0] rd;
  logic err;

  always #2.5 clk_i = ~clk_i;

  eeprom_config_word_loader u_eeprom_config_word_loader (
    .clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .pstrb_i(pstrb), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .ee_req_o(ee_req), .ee_addr_o(ee_addr),
    .ee_ack_i(ee_ack), .ee_data_i(ee_data), .cfg_image_o(cfg_image),
    .load_done_o(load_done));

  eeprom_word_model u_eeprom_word_model (
    .clk_i(clk_i), .rstn_i(rstn_i), .req_i(ee_req), .addr_i(ee_addr),
    .words_i(words), .delay_i(delay), .ack_o(ee_ack), .data_o(ee_data));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk_i);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_i);
    penable <= 1'b1;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (pready !== 1'b1 && n < 4000);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 4000)
      error_cnt++;
  endtask

  task automatic wait_done;
    int n;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (load_done !== 1'b1 && n < 4000);
    if (n >= 4000)
      error_cnt++;
  endtask

  task automatic reload(input int k);
    words <= pat[k];
    ack_base = ack_n;
    apb(1'b1, 12'hc00, 32'h1);
    wait_done;
  endtask

  function automatic logic [31:0] exp_reg(input int p,
      input logic [9:0] off, input logic [7:0][15:0] w);
    logic [15:0] m;
    logic [15:0] c;
    logic [15:0] g;
    logic [31:0] r;
    m = w[3];
    c = w[6];
    g = w[7];
    r = 32'h0;
    if (w[0] !== 16'h1516)
      return r;
    case (off)
      10'h000: r = {w[2], w[1]};
      10'h03c: r = {23'h0, (p != 0) & m[15], 8'h0};
      10'h070: r = {17'h0, c[5], c[7], 13'h0};
      10'h074: r = {16'h0, c[6], 8'h0, (p == 0) ? {m[9], m[8], m[14],
        m[13], m[12:11], m[10]} : 7'h0};
      10'h08c: r = {25'h0, c[10], c[8], 1'b0, c[15], 1'b0, c[13],
        c[11]};
      10'h094: r = {17'h0, g[14:0]};
      10'h0b4: r = {w[5], w[4]};
      10'h0c4: r = {16'h0, c[4], 13'h0, c[1:0]};
      10'h0cc: r = {10'h0, (p != 0) & c[9], 1'b0, c[12], 1'b0, m[6:4],
        m[3:1], c[3:2], 10'h0};
      10'h0e4: r = {13'h0, g[15], 5'h0, c[14], 12'h0};
      10'h144: r = {31'h0, m[0]};
      default: r = 32'h0;
    endcase
    return r;
  endfunction

  task automatic check_map(input logic [7:0][15:0] w);
    for (int j = 1; j < 8; j++)
    begin
      logic [31:0] e;
      e = (w[0] === 16'h1516) ? {16'h0, w[j]} : 32'h0;
      check({16'h0, cfg_image[16*(7-j) +: 16]}, e);
    end
    for (int p = 0; p < 3; p++)
      for (int i = 0; i < 11; i++)
      begin
        apb(1'b0, {p[1:0], offs[i]}, 32'h0);
        check(rd, exp_reg(p, offs[i], w));
      end
  endtask

  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  always @(posedge clk_i)
    if (rstn_i && ee_ack === 1'b1)
    begin
      check({24'h0, ee_addr}, 32'((ack_n - ack_base) * 2));
      ack_n++;
    end

  initial
  begin
    repeat (20000) @(posedge clk_i);
    error_cnt++;
    report_and_stop;
  end

  initial
  begin
    pat[0] = {16'h5a5a, 16'ha5a5, 16'hdef0, 16'h9abc, 16'h5a5a, 16'h5678,
      16'h1234, 16'h1516};
    pat[1] = {16'ha5a5, 16'h5a5a, 16'h0fed, 16'hcba9, 16'ha5a5, 16'h8765,
      16'h4321, 16'h1516};
    pat[2] = {{7{16'hffff}}, 16'h1517};
    words = pat[0];
    repeat (10) @(posedge clk_i);
    check({31'h0, load_done}, 32'h0);
    check({31'h0, ee_req}, 32'h0);
    check(32'(cfg_image === eeprom_cfg_pkg::IMAGE_RST), 32'h1);
    rstn_i <= 1'b1;
    // Issued at once: must stall until the slow load is over
    apb(1'b0, 12'h000, 32'h0);
    check({31'h0, load_done}, 32'h1);
    check(rd, 32'h5678_1234);
    check(ack_n, 8);
    check_map(pat[0]);
    apb(1'b0, 12'hc04, 32'h0);
    check(rd, 32'h3);
    $display("test first_load done");
    delay <= 4'h0;
    reload(1);
    check(ack_n - ack_base, 8);
    apb(1'b1, 12'h400, 32'hffff_ffff);
    check({31'h0, err}, 32'h0);
    check_map(pat[1]);
    $display("test second_load done");
    for (int i = 0; i < 2; i++)
    begin
      apb(1'b0, (i == 0) ? 12'h810 : 12'hc08, 32'h0);
      check({31'h0, err}, 32'h1);
      check(rd, 32'h0);
    end
    // Reload needs byte lane 0; without it the load must stay done
    pstrb <= 4'he;
    apb(1'b1, 12'hc00, 32'h1);
    pstrb <= 4'hf;
    @(posedge clk_i);
    check({31'h0, err}, 32'h0);
    check({31'h0, load_done}, 32'h1);
    $display("test unmapped done");
    delay <= 4'h2;
    reload(2);
    check(ack_n - ack_base, 1);
    check(32'(cfg_image === eeprom_cfg_pkg::IMAGE_RST), 32'h1);
    apb(1'b0, 12'hc04, 32'h0);
    check(rd, 32'h5);
    check_map(pat[2]);
    $display("test bad_signature done");
    reload(0);
    check_map(pat[0]);
    $display("test recovery done");
    report_and_stop;
  end
endmodule
